// [include/sdb_pkg.sv]
package sdb_pkg;
  localparam logic [7:0]  OP_DEFECT = 8'h37;
  localparam logic [7:0]  OP_WBUF = 8'h3B;
  localparam logic [7:0]  OP_RBUF = 8'h3C;
  localparam logic [7:0]  OP_RLONG = 8'h3E;
  localparam int          P_BIT = 4;
  localparam int          G_BIT = 3;
  localparam logic [2:0]  FMT_PHYS = 3'h5;
  localparam logic [2:0]  FMT_BOFS = 3'h4;
  localparam logic [2:0]  MODE_COMB = 3'h0;
  localparam logic [2:0]  MODE_DATA = 3'h2;
  localparam logic [2:0]  MODE_DESC = 3'h3;
  localparam logic [3:0]  KEY_NONE = 4'h0;
  localparam logic [3:0]  KEY_RECOV = 4'h1;
  localparam logic [3:0]  KEY_ILLEGAL = 4'h5;
  localparam logic [7:0]  ASC_NONE = 8'h00;
  localparam logic [7:0]  ASC_BAD_OP = 8'h20;
  localparam logic [7:0]  ASC_BAD_FIELD = 8'h24;
  localparam logic [23:0] HDR_BYTES = 24'h000004;
  localparam logic [23:0] LONG_LEN = 24'h00020E;
  localparam logic [23:0] LONG_DATA = 24'h000200;
  localparam logic [23:0] BUF_BYTES = 24'h000200;
  localparam int          BUF_DEPTH = 512;
  localparam int          DEF_ENTRIES = 8;
  localparam int          CDB_BYTES = 10;
  localparam logic [7:0]  ADDR_CTRL = 8'h00;
  localparam logic [7:0]  ADDR_STAT = 8'h04;
  localparam logic [7:0]  ADDR_DEF_IDX = 8'h08;
  localparam logic [7:0]  ADDR_DEF_CH = 8'h0C;
  localparam logic [7:0]  ADDR_DEF_SEC = 8'h10;
  localparam logic [7:0]  ADDR_DEF_OFS = 8'h14;
  localparam logic [7:0]  ADDR_LIST_CNT = 8'h18;
  localparam logic [1:0]  CDB_PAGE = 2'h1;
  localparam int          CTRL_START_BIT = 0;
  localparam int          CTRL_CLR_BIT = 1;

  typedef struct packed {
    logic       busy;
    logic       done;
    logic       chk;
    logic [3:0] key;
    logic [7:0] asc;
  } sdb_stat_t;

  localparam sdb_stat_t STAT_RST = '{1'b0, 1'b0, 1'b0, 4'h0, 8'h00};

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_DECODE = 3'b001,
    S_DIN    = 3'b010,
    S_DOUT   = 3'b011,
    S_FINISH = 3'b100
  } sdb_state_t;

  typedef enum logic [2:0] {
    K_DEFECT    = 3'b000,
    K_RBUF_COMB = 3'b001,
    K_RBUF_DATA = 3'b010,
    K_RBUF_DESC = 3'b011,
    K_RLONG     = 3'b100,
    K_WBUF_COMB = 3'b101,
    K_WBUF_DATA = 3'b110
  } sdb_kind_t;
endpackage : sdb_pkg

// [hw/sdb_cmd_decoder.sv]
`timescale 1ns/1ns
`default_nettype none
module sdb_cmd_decoder (
  input  wire logic          core_clk_in,
  input  wire logic          rst_n_in,
  input  wire logic [7:0]    reg_addr_in,
  input  wire logic [31:0]   reg_wdata_in,
  input  wire logic          reg_wr_in,
  input  wire logic          reg_rd_in,
  output logic      [31:0]   reg_rdata_out,
  output logic      [7:0]    din_data_out,
  output logic               din_valid_out,
  input  wire logic          din_ready_in,
  input  wire logic [7:0]    dout_data_in,
  input  wire logic          dout_valid_in,
  output logic               dout_ready_out,
  input  wire logic [111:0]  long_chk_in
);
  sdb_pkg::sdb_state_t state_q, state_d;
  sdb_pkg::sdb_kind_t  kind_q, dec_kind;
  sdb_pkg::sdb_stat_t  stat_q;

  logic [7:0]  cdb_q [sdb_pkg::CDB_BYTES];
  logic [7:0]  buf_mem [sdb_pkg::BUF_DEPTH];
  logic [31:0] def_ch_q [sdb_pkg::DEF_ENTRIES];
  logic [31:0] def_sec_q [sdb_pkg::DEF_ENTRIES];
  logic [31:0] def_ofs_q [sdb_pkg::DEF_ENTRIES];
  logic [2:0]  def_idx_q;
  logic [3:0]  pcnt_q;
  logic [3:0]  gcnt_q;
  logic [23:0] idx_q;
  logic [23:0] tot_q;
  logic [23:0] ofs_q;
  logic [2:0]  base_q;
  logic [2:0]  fmt_q;
  logic        p_q;
  logic        g_q;
  logic [15:0] list_len_q;
  logic [3:0]  key_q;
  logic [7:0]  asc_q;
  logic [7:0]  din_q;
  logic        dval_q;
  logic        drdy_q;
  logic [31:0] rdata_q;

  logic [23:0] dec_tot;
  logic [3:0]  dec_key;
  logic [7:0]  dec_asc;
  logic        dec_bad;
  logic [7:0]  byte_w;

  function automatic logic [23:0] min24(input logic [23:0] a,
                                        input logic [23:0] b);
    min24 = (a < b) ? a : b;
  endfunction : min24

  // Register decode
  wire        cdb_hit = reg_addr_in[7:6] == sdb_pkg::CDB_PAGE;
  wire [3:0]  cdb_sel = reg_addr_in[5:2];
  wire        cdb_ok  = cdb_sel < 4'hA;
  wire        wr_ctrl = reg_wr_in && reg_addr_in == sdb_pkg::ADDR_CTRL;
  wire        idle    = state_q == sdb_pkg::S_IDLE;
  wire        start_w = wr_ctrl && reg_wdata_in[sdb_pkg::CTRL_START_BIT] && idle;
  wire        clr_w   = wr_ctrl && reg_wdata_in[sdb_pkg::CTRL_CLR_BIT];

  // Command fields
  wire [7:0]  op       = cdb_q[0];
  wire [2:0]  mode     = cdb_q[1][2:0];
  wire        p_flag   = cdb_q[2][sdb_pkg::P_BIT];
  wire        g_flag   = cdb_q[2][sdb_pkg::G_BIT];
  wire [2:0]  fmt_req  = cdb_q[2][2:0];
  wire [23:0] alloc16  = {8'h00, cdb_q[7], cdb_q[8]};
  wire [23:0] len24    = {cdb_q[6], cdb_q[7], cdb_q[8]};
  wire [23:0] bofs     = {cdb_q[3], cdb_q[4], cdb_q[5]};
  wire        fmt_good = fmt_req == sdb_pkg::FMT_PHYS ||
                         fmt_req == sdb_pkg::FMT_BOFS;
  wire [4:0]  ndesc    = (p_flag ? {1'b0, pcnt_q} : 5'h00) +
                         (g_flag ? {1'b0, gcnt_q} : 5'h00);
  wire [23:0] def_avl  = sdb_pkg::HDR_BYTES + {16'h0000, ndesc, 3'h0};
  wire        ofs_ok   = bofs < sdb_pkg::BUF_BYTES;
  wire [23:0] buf_left = ofs_ok ? sdb_pkg::BUF_BYTES - bofs : 24'h000000;

  // Command decode and length limits
  always_comb begin
    dec_kind = sdb_pkg::K_DEFECT;
    dec_tot  = 24'h000000;
    dec_key  = sdb_pkg::KEY_NONE;
    dec_asc  = sdb_pkg::ASC_NONE;
    dec_bad  = 1'b0;
    unique case (op)
      sdb_pkg::OP_DEFECT: begin
        dec_tot = min24(alloc16, def_avl);
        if (!fmt_good) begin
          dec_key = sdb_pkg::KEY_RECOV;
        end
      end
      sdb_pkg::OP_WBUF: begin
        dec_tot = len24;
        if (cdb_q[2] != 8'h00) begin
          dec_bad = 1'b1;
        end else if (mode == sdb_pkg::MODE_COMB) begin
          dec_kind = sdb_pkg::K_WBUF_COMB;
          dec_bad  = len24 > sdb_pkg::HDR_BYTES + sdb_pkg::BUF_BYTES;
        end else if (mode == sdb_pkg::MODE_DATA) begin
          dec_kind = sdb_pkg::K_WBUF_DATA;
          dec_bad  = len24 > sdb_pkg::BUF_BYTES;
        end else begin
          dec_bad = 1'b1;
        end
        dec_key = dec_bad ? sdb_pkg::KEY_ILLEGAL : sdb_pkg::KEY_NONE;
        dec_asc = dec_bad ? sdb_pkg::ASC_BAD_FIELD : sdb_pkg::ASC_NONE;
      end
      sdb_pkg::OP_RBUF: begin
        if (mode == sdb_pkg::MODE_COMB) begin
          dec_kind = sdb_pkg::K_RBUF_COMB;
          dec_tot  = min24(len24, sdb_pkg::HDR_BYTES + buf_left);
        end else if (mode == sdb_pkg::MODE_DATA) begin
          dec_kind = sdb_pkg::K_RBUF_DATA;
          dec_tot  = min24(len24, buf_left);
        end else if (mode == sdb_pkg::MODE_DESC) begin
          dec_kind = sdb_pkg::K_RBUF_DESC;
          dec_tot  = min24(len24, sdb_pkg::HDR_BYTES);
        end else begin
          dec_bad = 1'b1;
          dec_key = sdb_pkg::KEY_ILLEGAL;
          dec_asc = sdb_pkg::ASC_BAD_FIELD;
        end
      end
      sdb_pkg::OP_RLONG: begin
        dec_kind = sdb_pkg::K_RLONG;
        dec_tot  = sdb_pkg::LONG_LEN;
        if ({8'h00, cdb_q[7], cdb_q[8]} != sdb_pkg::LONG_LEN) begin
          dec_bad = 1'b1;
          dec_key = sdb_pkg::KEY_ILLEGAL;
          dec_asc = sdb_pkg::ASC_BAD_FIELD;
        end
      end
      default: begin
        dec_bad = 1'b1;
        dec_key = sdb_pkg::KEY_ILLEGAL;
        dec_asc = sdb_pkg::ASC_BAD_OP;
      end
    endcase
  end

  wire dec_out = dec_kind == sdb_pkg::K_WBUF_COMB ||
                 dec_kind == sdb_pkg::K_WBUF_DATA;

  // Data-in byte generation
  wire        in_din  = state_q == sdb_pkg::S_DIN;
  wire        adv     = in_din && (!dval_q || din_ready_in);
  wire        more    = idx_q < tot_q;
  wire [23:0] didx    = idx_q - sdb_pkg::HDR_BYTES;
  wire [2:0]  dent    = base_q + didx[5:3];
  wire        use_ofs = fmt_q == sdb_pkg::FMT_BOFS;
  wire [63:0] dword   = {def_ch_q[dent],
                         use_ofs ? def_ofs_q[dent] : def_sec_q[dent]};
  wire [7:0]  dbyte   = dword[{3'h7 - didx[2:0], 3'h0} +: 8];
  wire        comb_k  = kind_q == sdb_pkg::K_RBUF_COMB;
  wire [8:0]  raddr   = ofs_q[8:0] + (comb_k ? didx[8:0] : idx_q[8:0]);
  wire [7:0]  lbyte   = long_chk_in[{4'hD - idx_q[3:0], 3'h0} +: 8];
  wire [31:0] bhdr    = {8'h00, sdb_pkg::BUF_BYTES};
  wire [7:0]  hbyte   = bhdr[{2'h3 - idx_q[1:0], 3'h0} +: 8];
  wire        in_hdr  = idx_q < sdb_pkg::HDR_BYTES;
  wire [31:0] dhdr_w  = {8'h00, 3'h0, p_q, g_q, fmt_q, list_len_q};
  wire [7:0]  dhdr    = dhdr_w[{2'h3 - idx_q[1:0], 3'h0} +: 8];
  wire [7:0]  rbyte   = (idx_q < sdb_pkg::LONG_DATA) ? buf_mem[idx_q[8:0]] : lbyte;

  always_comb begin
    byte_w = 8'h00;
    unique case (kind_q)
      sdb_pkg::K_DEFECT:    byte_w = in_hdr ? dhdr : dbyte;
      sdb_pkg::K_RBUF_COMB: byte_w = in_hdr ? hbyte : buf_mem[raddr];
      sdb_pkg::K_RBUF_DATA: byte_w = buf_mem[raddr];
      sdb_pkg::K_RBUF_DESC: byte_w = hbyte;
      sdb_pkg::K_RLONG:     byte_w = rbyte;
      default:              byte_w = 8'h00;
    endcase
  end

  // Data-out storage
  wire       acc    = drdy_q && dout_valid_in;
  wire       wcomb  = kind_q == sdb_pkg::K_WBUF_COMB;
  wire       mem_we = acc && !(wcomb && in_hdr);
  wire [8:0] waddr  = wcomb ? didx[8:0] : idx_q[8:0];
  wire       last_o = acc && (idx_q + 24'h000001 == tot_q);

  // Sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sdb_pkg::S_IDLE:   if (start_w) state_d = sdb_pkg::S_DECODE;
      sdb_pkg::S_DECODE: begin
        if (dec_bad || dec_tot == 24'h000000) begin
          state_d = sdb_pkg::S_FINISH;
        end else if (dec_out) begin
          state_d = sdb_pkg::S_DOUT;
        end else begin
          state_d = sdb_pkg::S_DIN;
        end
      end
      sdb_pkg::S_DIN:    if (adv && !more) state_d = sdb_pkg::S_FINISH;
      sdb_pkg::S_DOUT:   if (last_o) state_d = sdb_pkg::S_FINISH;
      sdb_pkg::S_FINISH: state_d = sdb_pkg::S_IDLE;
      default:           state_d = sdb_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_q <= sdb_pkg::S_IDLE;
      drdy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      drdy_q  <= state_d == sdb_pkg::S_DOUT;
    end
  end

  // Command capture at decode
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      kind_q     <= sdb_pkg::K_DEFECT;
      tot_q      <= 24'h000000;
      ofs_q      <= 24'h000000;
      base_q     <= 3'h0;
      fmt_q      <= sdb_pkg::FMT_PHYS;
      p_q        <= 1'b0;
      g_q        <= 1'b0;
      list_len_q <= 16'h0000;
      key_q      <= sdb_pkg::KEY_NONE;
      asc_q      <= sdb_pkg::ASC_NONE;
    end else if (state_q == sdb_pkg::S_DECODE) begin
      kind_q     <= dec_kind;
      tot_q      <= dec_tot;
      ofs_q      <= (op == sdb_pkg::OP_RBUF) ? bofs : 24'h000000;
      base_q     <= p_flag ? 3'h0 : pcnt_q[2:0];
      fmt_q      <= fmt_good ? fmt_req : sdb_pkg::FMT_PHYS;
      p_q        <= p_flag;
      g_q        <= g_flag;
      list_len_q <= {8'h00, ndesc, 3'h0};
      key_q      <= dec_key;
      asc_q      <= dec_asc;
    end
  end

  // Byte counter and data-in output stage
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      idx_q  <= 24'h000000;
      din_q  <= 8'h00;
      dval_q <= 1'b0;
    end else if (state_q == sdb_pkg::S_DECODE) begin
      idx_q  <= 24'h000000;
    end else if (adv) begin
      dval_q <= more;
      if (more) begin
        din_q <= byte_w;
        idx_q <= idx_q + 24'h000001;
      end
    end else if (acc) begin
      idx_q <= idx_q + 24'h000001;
    end
  end

  // Buffer memory, never the medium
  always_ff @(posedge core_clk_in) begin
    if (mem_we) begin
      buf_mem[waddr] <= dout_data_in;
    end
  end

  // Status: completion wins over a clear in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      stat_q <= sdb_pkg::STAT_RST;
    end else if (state_q == sdb_pkg::S_FINISH) begin
      stat_q.busy <= 1'b0;
      stat_q.done <= 1'b1;
      stat_q.chk  <= key_q != sdb_pkg::KEY_NONE;
      stat_q.key  <= key_q;
      stat_q.asc  <= asc_q;
    end else if (start_w) begin
      stat_q <= '{1'b1, 1'b0, 1'b0, 4'h0, 8'h00};
    end else if (clr_w) begin
      stat_q.done <= 1'b0;
    end
  end

  // Software-visible setup registers
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      def_idx_q <= 3'h0;
      pcnt_q    <= 4'h0;
      gcnt_q    <= 4'h0;
    end else if (reg_wr_in && idle) begin
      if (reg_addr_in == sdb_pkg::ADDR_DEF_IDX) begin
        def_idx_q <= reg_wdata_in[2:0];
      end
      if (reg_addr_in == sdb_pkg::ADDR_LIST_CNT) begin
        pcnt_q <= reg_wdata_in[3:0];
        gcnt_q <= reg_wdata_in[7:4];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reg_wr_in && idle) begin
      if (reg_addr_in == sdb_pkg::ADDR_DEF_CH) begin
        def_ch_q[def_idx_q] <= reg_wdata_in;
      end
      if (reg_addr_in == sdb_pkg::ADDR_DEF_SEC) begin
        def_sec_q[def_idx_q] <= reg_wdata_in;
      end
      if (reg_addr_in == sdb_pkg::ADDR_DEF_OFS) begin
        def_ofs_q[def_idx_q] <= reg_wdata_in;
      end
    end
  end

  generate
    for (genvar i = 0; i < sdb_pkg::CDB_BYTES; i++) begin : g_cdb
      always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
          cdb_q[i] <= 8'h00;
        end else if (reg_wr_in && idle && cdb_hit && cdb_sel == 4'(i)) begin
          cdb_q[i] <= reg_wdata_in[7:0];
        end
      end
    end
  endgenerate

  // Read data, one cycle after the strobe
  wire [31:0] rd_w =
    (reg_addr_in == sdb_pkg::ADDR_STAT)     ? {17'h00000, stat_q} :
    (reg_addr_in == sdb_pkg::ADDR_DEF_IDX)  ? {29'h00000000, def_idx_q} :
    (reg_addr_in == sdb_pkg::ADDR_LIST_CNT) ? {24'h000000, gcnt_q, pcnt_q} :
    (cdb_hit && cdb_ok)                     ? {24'h000000, cdb_q[cdb_sel]} :
                                              32'h00000000;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= reg_rd_in ? rd_w : 32'h00000000;
    end
  end

  assign reg_rdata_out  = rdata_q;
  assign din_data_out   = din_q;
  assign din_valid_out  = dval_q;
  assign dout_ready_out = drdy_q;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  wire dec_now = state_q == sdb_pkg::S_DECODE;

  op_decode_a: assert property (dec_now && op == sdb_pkg::OP_DEFECT
    |=> kind_q == sdb_pkg::K_DEFECT && !drdy_q)
    else $error("defect opcode not decoded");
  no_lists_a: assert property (dec_now && op == sdb_pkg::OP_DEFECT &&
    !p_flag && !g_flag |=> tot_q <= sdb_pkg::HDR_BYTES)
    else $error("descriptors sent without list flags");
  bad_format_a: assert property (dec_now && op == sdb_pkg::OP_DEFECT &&
    !fmt_good |=> fmt_q == sdb_pkg::FMT_PHYS)
    else $error("unsupported format not replaced");
  alloc_limit_a: assert property (in_din && kind_q == sdb_pkg::K_DEFECT
    |-> tot_q <= {8'h00, cdb_q[7], cdb_q[8]})
    else $error("defect transfer exceeds allocation");
  list_len_a: assert property (adv && more && kind_q == sdb_pkg::K_DEFECT &&
    idx_q == 24'h000003 |=> din_data_out == list_len_q[7:0] && din_valid_out)
    else $error("defect list length byte wrong");
  buf_select_a: assert property (dec_now && op == sdb_pkg::OP_WBUF &&
    cdb_q[2] != 8'h00 |=> ##1 stat_q.chk && stat_q.key == sdb_pkg::KEY_ILLEGAL)
    else $error("buffer select not rejected");
  comb_skip_a: assert property (acc && wcomb && in_hdr |-> !mem_we)
    else $error("combined header stored");
  zero_alloc_a: assert property (dec_now && op == sdb_pkg::OP_RBUF &&
    len24 == 24'h000000 |=> state_q == sdb_pkg::S_FINISH ##1 !din_valid_out)
    else $error("data sent for zero allocation");
  avail_len_a: assert property (adv && more && comb_k &&
    idx_q == 24'h000002 |=> din_data_out == sdb_pkg::BUF_BYTES[15:8])
    else $error("available length byte wrong");
  long_len_a: assert property (dec_now && op == sdb_pkg::OP_RLONG &&
    len24[15:0] != sdb_pkg::LONG_LEN[15:0] |=> ##1 stat_q.asc == sdb_pkg::ASC_BAD_FIELD)
    else $error("long read length not checked");

  defect_run_c: cover property (in_din && kind_q == sdb_pkg::K_DEFECT ##[1:40]
    state_q == sdb_pkg::S_FINISH);
  wbuf_run_c: cover property (last_o && wcomb);
  rlong_run_c: cover property (in_din && kind_q == sdb_pkg::K_RLONG && !more);
endmodule : sdb_cmd_decoder
`default_nettype wire

// [testbench/sdb_init_model.sv]
`timescale 1ns/1ns
`default_nettype none
module sdb_init_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       slow_in,
  input  wire logic [7:0] tx_base_in,
  input  wire logic [7:0] din_data_in,
  input  wire logic       din_valid_in,
  output logic            din_ready_out,
  output logic      [7:0] dout_data_out,
  output logic            dout_valid_out,
  input  wire logic       dout_ready_in
);
  logic [7:0] rx_q[$];
  int         n_tx;
  logic [7:0] tx_v;

  assign tx_v          = tx_base_in + 8'(n_tx);
  // Released data lines show the inverse of the next byte
  assign dout_data_out = dout_valid_out ? tx_v : ~tx_v;

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      din_ready_out  <= 1'b0;
      dout_valid_out <= 1'b0;
      n_tx           <= 0;
    end else begin
      if (din_valid_in && din_ready_out) begin
        rx_q.push_back(din_data_in);
      end
      din_ready_out  <= slow_in ? !din_ready_out : 1'b1;
      dout_valid_out <= 1'b1;
      if (dout_valid_out && dout_ready_in) begin
        n_tx <= n_tx + 1;
      end
    end
  end
endmodule : sdb_init_model
`default_nettype wire

// [testbench/tb_sdb_cmd_decoder.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_sdb_cmd_decoder;
  localparam logic [111:0] LCHK = 112'hA1A2A3A4A5A6A7A8A9AAABACADAE;
  logic         clk   = 1'b0;
  logic         rst_n = 1'b0;
  logic [7:0]   addr  = 8'h00;
  logic [31:0]  wdata = 32'h0;
  logic         wr    = 1'b0;
  logic         rd    = 1'b0;
  logic         slow  = 1'b0;
  logic [31:0]  rdata;
  logic [7:0]   din_d;
  logic         din_v;
  logic         din_r;
  logic [7:0]   dout_d;
  logic         dout_v;
  logic         dout_r;
  logic [7:0]   eb[512];
  logic [7:0]   ex[$];
  logic [31:0]  s;
  int           failures = 0;
  int           n_checks = 0;
  int           n0;

  sdb_cmd_decoder i_sdb_cmd_decoder (
    .core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .din_data_out(din_d),
    .din_valid_out(din_v), .din_ready_in(din_r), .dout_data_in(dout_d),
    .dout_valid_in(dout_v), .dout_ready_out(dout_r), .long_chk_in(LCHK));

  sdb_init_model i_sdb_init_model (
    .clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .tx_base_in(8'h40),
    .din_data_in(din_d), .din_valid_in(din_v), .din_ready_out(din_r),
    .dout_data_out(dout_d), .dout_valid_out(dout_v), .dout_ready_in(dout_r));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic pb(input logic [31:0] v);
    for (int j = 3; j >= 0; j--) ex.push_back(v[8 * j +: 8]);
  endtask : pb

  function automatic logic [31:0] dw(input int i, input int f);
    case (f)
      0: return {24'h000100 + 24'(i), 8'h20 + 8'(i)};
      1: return 32'h00000030 + 32'(i);
      default: return 32'h00010000 + 32'(i * 512);
    endcase
  endfunction : dw

  task automatic run(input logic [7:0] op, b1, b2, input logic [23:0] off, len,
                     input logic [3:0] key, input logic [7:0] asc);
    logic [79:0] v;
    logic [7:0]  q[$];
    int          k;
    v = {op, b1, b2, off, len, 8'h00};
    i_sdb_init_model.rx_q.delete();
    for (int i = 0; i < 10; i++) wr_reg(8'h40 + 8'(4 * i), {24'h0, v[79 - 8 * i -: 8]});
    wr_reg(sdb_pkg::ADDR_CTRL, 32'h00000001);
    k = 0;
    s = 32'h0;
    while (!s[13] && k < 2000) begin
      rd_reg(sdb_pkg::ADDR_STAT, s);
      k++;
    end
    check(s, {17'h0, 2'b01, key != 4'h0, key, asc});
    q = i_sdb_init_model.rx_q;
    check(32'(q.size()), 32'(ex.size()));
    foreach (ex[i]) begin
      if (i < q.size()) check({24'h0, q[i]}, {24'h0, ex[i]});
    end
    wr_reg(sdb_pkg::ADDR_CTRL, 32'h00000002);
    ex.delete();
  endtask : run

  task automatic finish_test;
    $display("Checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  initial begin
    #(60000 * 50);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(sdb_pkg::ADDR_STAT, s);
    check(s, 32'h0);
    wr_reg(sdb_pkg::ADDR_LIST_CNT, 32'h00000012);
    for (int i = 0; i < 3; i++) begin
      wr_reg(sdb_pkg::ADDR_DEF_IDX, 32'(i));
      wr_reg(sdb_pkg::ADDR_DEF_CH, dw(i, 0));
      wr_reg(sdb_pkg::ADDR_DEF_SEC, dw(i, 1));
      wr_reg(sdb_pkg::ADDR_DEF_OFS, dw(i, 2));
    end
    pb({16'h001D, 16'h0018});
    for (int i = 0; i < 3; i++) begin
      pb(dw(i, 0));
      pb(dw(i, 1));
    end
    run(8'h37, 8'h00, 8'h1D, 24'h0, 24'h000100, 4'h0, 8'h00);
    pb({16'h0014, 16'h0010});
    pb(dw(0, 0));
    pb(dw(0, 2));
    repeat (2) void'(ex.pop_back());
    run(8'h37, 8'h00, 8'h14, 24'h0, 24'h00000A, 4'h0, 8'h00);
    pb({16'h000D, 16'h0008});
    pb(dw(2, 0));
    pb(dw(2, 1));
    run(8'h37, 8'h00, 8'h0B, 24'h0, 24'h000064, 4'h1, 8'h00);
    pb(32'h00050000);
    run(8'h37, 8'h00, 8'h05, 24'h0, 24'h000064, 4'h0, 8'h00);
    run(8'h37, 8'h00, 8'h1D, 24'h0, 24'h000000, 4'h0, 8'h00);
    $display("Test defect list done");
    n0 = i_sdb_init_model.n_tx;
    run(8'h3B, 8'h02, 8'h00, 24'h0, 24'h000200, 4'h0, 8'h00);
    for (int k = 0; k < 512; k++) eb[k] = 8'h40 + 8'(n0 + k);
    n0 = i_sdb_init_model.n_tx;
    run(8'h3B, 8'h00, 8'h00, 24'h0, 24'h00000C, 4'h0, 8'h00);
    check(32'(i_sdb_init_model.n_tx - n0), 32'h0000000C);
    for (int k = 0; k < 8; k++) eb[k] = 8'h40 + 8'(n0 + 4 + k);
    pb(32'h00000200);
    for (int k = 0; k < 6; k++) ex.push_back(eb[k]);
    run(8'h3C, 8'h00, 8'h00, 24'h0, 24'h00000A, 4'h0, 8'h00);
    ex.push_back(eb[510]);
    ex.push_back(eb[511]);
    run(8'h3C, 8'h02, 8'h00, 24'h0001FE, 24'h000008, 4'h0, 8'h00);
    pb(32'h00000200);
    run(8'h3C, 8'h03, 8'h00, 24'h0, 24'h000004, 4'h0, 8'h00);
    run(8'h3C, 8'h00, 8'h00, 24'h0, 24'h000000, 4'h0, 8'h00);
    $display("Test buffer done");
    slow <= 1'b1;
    for (int k = 0; k < 512; k++) ex.push_back(eb[k]);
    for (int j = 0; j < 14; j++) ex.push_back(LCHK[111 - 8 * j -: 8]);
    run(8'h3E, 8'h00, 8'h00, 24'h0, 24'h00020E, 4'h0, 8'h00);
    slow <= 1'b0;
    run(8'h3E, 8'h00, 8'h00, 24'h0, 24'h00020D, 4'h5, 8'h24);
    $display("Test long read done");
    n0 = i_sdb_init_model.n_tx;
    run(8'h3B, 8'h02, 8'h01, 24'h0, 24'h000008, 4'h5, 8'h24);
    run(8'h3B, 8'h02, 8'h00, 24'h0, 24'h000201, 4'h5, 8'h24);
    run(8'h3B, 8'h00, 8'h00, 24'h0, 24'h000205, 4'h5, 8'h24);
    for (int m = 1; m < 8; m++) begin
      if (m != 2) run(8'h3B, 8'(m), 8'h00, 24'h0, 24'h000008, 4'h5, 8'h24);
      if (m == 1 || m > 3) run(8'h3C, 8'(m), 8'h00, 24'h0, 24'h000008, 4'h5, 8'h24);
    end
    run(8'h3F, 8'h00, 8'h00, 24'h0, 24'h000008, 4'h5, 8'h20);
    check(32'(i_sdb_init_model.n_tx), 32'(n0));
    $display("Test refusals done");
    finish_test();
  end
endmodule : tb_sdb_cmd_decoder
`default_nettype wire
